// ### src/rps_sequencer.sv
// rail power-up / power-down sequencer with wake logic and apb registers
// assumes wake pins synchronous to clk_i and fault flags from analog monitors
// Operation
// - ten strobes, nine delays per sequence
// - each rail on one strobe, strobes shared
// - each delay lasts 2 to 5 ms
// - fire strobe, wait delay, repeat to end
// - strobes and delays held in host registers
// - off wakes on edges, enable, supply arrival with detect low
// - pre-off wakes on edges or enable rise
// - suspend wakes on edges or enable level
// - wake enters wait state, starts power-up
// - 20 s without enable, pins high: power-down
// - enable moves to active, detect ignored
// - strobe zero rails untouched by sequencing
// - host rail writes locked while sequencing
// - enable bits mirror rails, sequencer updates them
// - power-down reverse from ten, tenfold delays
// - destination state 500 ms after power-down start
// - active: enable low starts power-down
`default_nettype none
module rps_sequencer #(
    parameter int N_RAILS = rps_pkg::N_RAILS_DEF,
    parameter int CYC_PER_MS = rps_pkg::CYC_PER_MS,
    parameter int WAIT_TIMEOUT_MS = rps_pkg::WAIT_TIMEOUT_MS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic pushbutton_input_i,
    input wire logic adapter_detect_input_i,
    input wire logic power_enable_input_i,
    input wire logic supply_arrival_i,
    input wire logic undervoltage_lockout_i,
    input wire logic overtemp_shutdown_i,
    output logic [N_RAILS-1:0] rail_en_o,
    output logic [N_RAILS-1:0] rail_discharge_o,
    output rps_pkg::rps_state_t state_o,
    output logic seq_busy_o
);
    localparam int TW = $clog2(CYC_PER_MS);
    localparam int WW = $clog2(WAIT_TIMEOUT_MS + 1);
    localparam int PW = $clog2(rps_pkg::PD_TOTAL_MS + 1);

    typedef struct packed {
        rps_pkg::rps_state_t st;
        rps_pkg::rps_state_t dest;
        logic pb_q;
        logic ac_q;
        logic en_q;
        logic up;
        logic dn;
        logic [3:0] strobe;
        logic [5:0] dly;
        logic [TW-1:0] tick;
        logic [WW-1:0] wait_ms;
        logic [PW-1:0] pd_ms;
        logic [N_RAILS-1:0] rail_en;
        logic [N_RAILS-1:0] dis;
    } rps_core_t;

    rps_core_t s_r;
    rps_core_t s_nxt;
    logic [4*N_RAILS-1:0] strobe_cfg;
    logic [17:0] delay_cfg;
    logic suspend_sel;
    logic rail_wr;
    logic [N_RAILS-1:0] rail_wdata;
    logic [31:0] status;
    logic busy;
    logic tick;
    logic ok;
    logic pb_fall;
    logic ac_fall;
    logic en_rise;
    logic go_up;
    logic go_dn;
    rps_pkg::rps_state_t dn_dest;
    logic fire_now;
    logic [N_RAILS-1:0] fire_mask;
    logic [N_RAILS-1:0] zero_mask;

    // field value N selects strobe N; 11..15 never match and act as zero
    function automatic logic [3:0] strobe_of(input logic [4*N_RAILS-1:0] cfg, input int rail);
        return cfg[rail*rps_pkg::STROBE_FIELD_W +: rps_pkg::STROBE_FIELD_W];
    endfunction : strobe_of

    // delay k sits between strobe k and k+1; the code cannot leave 2..5 ms
    function automatic logic [5:0] dly_ms(input logic [17:0] cfg, input logic [3:0] k);
        logic [1:0] code;
        code = cfg[(int'(k) - 1) * rps_pkg::DLY_CODE_W +: rps_pkg::DLY_CODE_W];
        return 6'(rps_pkg::DLY_MIN_MS) + {4'h0, code};
    endfunction : dly_ms

    rps_apb_regs #(.N_RAILS(N_RAILS)) u_regs (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .pready_o(pready_o),
        .prdata_o(prdata_o),
        .pslverr_o(pslverr_o),
        .rail_en_i(s_r.rail_en),
        .status_i(status),
        .busy_i(busy),
        .strobe_cfg_o(strobe_cfg),
        .delay_cfg_o(delay_cfg),
        .suspend_sel_o(suspend_sel),
        .rail_wr_o(rail_wr),
        .rail_wdata_o(rail_wdata)
    );

    assign busy = s_r.up | s_r.dn;
    assign tick = (s_r.tick == TW'(CYC_PER_MS - 1));
    assign ok = ~undervoltage_lockout_i & ~overtemp_shutdown_i;
    assign pb_fall = s_r.pb_q & ~pushbutton_input_i;
    assign ac_fall = s_r.ac_q & ~adapter_detect_input_i;
    assign en_rise = ~s_r.en_q & power_enable_input_i;
    assign fire_now = busy & (s_r.dly == 6'h00) & ~go_up & ~go_dn;
    assign status = {26'h000_0000, s_r.dn, s_r.up, 1'b0, s_r.st};
    assign rail_en_o = s_r.rail_en;
    assign rail_discharge_o = s_r.dis;
    assign state_o = s_r.st;
    assign seq_busy_o = busy;

    always_comb begin
        for (int i = 0; i < N_RAILS; i++) begin
            fire_mask[i] = (strobe_of(strobe_cfg, i) == s_r.strobe);
            zero_mask[i] = (strobe_of(strobe_cfg, i) == 4'h0);
        end
    end

    // wake and power-down decisions
    always_comb begin
        go_up = 1'b0;
        go_dn = 1'b0;
        dn_dest = rps_pkg::ST_OFF;
        unique case (s_r.st)
            rps_pkg::ST_OFF:
                go_up = ok & (pb_fall | ac_fall | en_rise |
                        (supply_arrival_i & ~adapter_detect_input_i));
            rps_pkg::ST_PRE_OFF:
                go_up = ok & (pb_fall | ac_fall | en_rise);
            rps_pkg::ST_SUSPEND:
                go_up = ok & (pb_fall | ac_fall | power_enable_input_i);
            rps_pkg::ST_WAIT_EN: begin
                if (!ok) begin
                    go_dn = 1'b1;
                    dn_dest = rps_pkg::ST_PRE_OFF;
                end else if (!power_enable_input_i && pushbutton_input_i &&
                             adapter_detect_input_i &&
                             s_r.wait_ms >= WW'(WAIT_TIMEOUT_MS)) begin
                    go_dn = 1'b1;
                end
            end
            rps_pkg::ST_ACTIVE: begin
                if (!ok) begin
                    go_dn = 1'b1;
                    dn_dest = rps_pkg::ST_PRE_OFF;
                end else if (!power_enable_input_i) begin
                    go_dn = 1'b1;
                    dn_dest = suspend_sel ? rps_pkg::ST_SUSPEND : rps_pkg::ST_OFF;
                end
            end
            rps_pkg::ST_PWR_DN: go_up = 1'b0;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = tick ? '0 : s_r.tick + 1'b1;
        s_nxt.pb_q = pushbutton_input_i;
        s_nxt.ac_q = adapter_detect_input_i;
        s_nxt.en_q = power_enable_input_i;
        if (rail_wr) begin
            // host writes only reach here when no sequence runs
            s_nxt.rail_en = rail_wdata;
            s_nxt.dis = s_r.dis & ~rail_wdata;
        end
        if (s_r.st == rps_pkg::ST_WAIT_EN && tick && s_r.wait_ms < WW'(WAIT_TIMEOUT_MS)) begin
            s_nxt.wait_ms = s_r.wait_ms + 1'b1;
        end
        // adapter detect is ignored once active; only enable and the fault flags matter there
        if (s_r.st == rps_pkg::ST_WAIT_EN && ok && power_enable_input_i) begin
            s_nxt.st = rps_pkg::ST_ACTIVE;
        end
        if (s_r.st == rps_pkg::ST_PWR_DN) begin
            if (s_r.pd_ms == PW'(rps_pkg::PD_TOTAL_MS)) begin
                s_nxt.st = s_r.dest;
                s_nxt.dn = 1'b0;
            end else if (tick) begin
                s_nxt.pd_ms = s_r.pd_ms + 1'b1;
            end
        end
        if (go_up) begin
            s_nxt.st = rps_pkg::ST_WAIT_EN;
            s_nxt.wait_ms = '0;
            s_nxt.up = 1'b1;
            s_nxt.dn = 1'b0;
            s_nxt.strobe = 4'h1;
            s_nxt.dly = 6'h00;
        end else if (go_dn) begin
            s_nxt.st = rps_pkg::ST_PWR_DN;
            s_nxt.dest = dn_dest;
            s_nxt.pd_ms = '0;
            s_nxt.up = 1'b0;
            s_nxt.dn = 1'b1;
            s_nxt.strobe = 4'(rps_pkg::N_STROBES);
            s_nxt.dly = 6'h00;
        end else if (busy && s_r.dly != 6'h00) begin
            if (tick) begin
                s_nxt.dly = s_r.dly - 1'b1;
            end
        end else if (busy) begin
            // fire the current strobe; rails on strobe zero never match
            if (s_r.up) begin
                s_nxt.rail_en = s_r.rail_en | fire_mask;
                s_nxt.dis = s_r.dis & ~fire_mask;
                if (s_r.strobe == 4'(rps_pkg::N_STROBES)) begin
                    s_nxt.up = 1'b0;
                end else begin
                    s_nxt.dly = dly_ms(delay_cfg, s_r.strobe);
                    s_nxt.strobe = s_r.strobe + 1'b1;
                end
            end else begin
                s_nxt.rail_en = s_r.rail_en & ~fire_mask;
                s_nxt.dis = s_r.dis | fire_mask;
                if (s_r.strobe != 4'h1) begin
                    s_nxt.dly = 6'(int'(dly_ms(delay_cfg, s_r.strobe - 1'b1)) *
                                rps_pkg::DOWN_FACTOR);
                    s_nxt.strobe = s_r.strobe - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_UP_ENDS_AT_TEN: assert property ($fell(s_r.up) && !s_r.dn |->
        $past(s_r.strobe) == 4'ha) else $error("power-up ended before strobe ten");
    AST_DLY_RANGE: assert property (s_r.up && $past(s_r.up) && $changed(s_r.strobe) |->
        s_r.dly >= 6'h02 && s_r.dly <= 6'h05) else $error("power-up delay out of range");
    AST_UP_FIRE: assert property (fire_now && s_r.up |=>
        ($past(fire_mask) & ~s_r.rail_en) == '0) else $error("strobe did not enable rails");
    AST_DN_FIRE: assert property (fire_now && s_r.dn |=>
        ($past(fire_mask) & (s_r.rail_en | ~s_r.dis)) == '0)
        else $error("strobe did not disable and discharge rails");
    AST_DN_START: assert property ($rose(s_r.dn) |-> s_r.strobe == 4'ha &&
        s_r.st == rps_pkg::ST_PWR_DN) else $error("power-down not starting at strobe ten");
    AST_UNSEQ_HOLD: assert property (busy |=>
        ((s_r.rail_en ^ $past(s_r.rail_en)) & $past(zero_mask)) == '0)
        else $error("unassigned rail changed during sequencing");
    AST_HOST_LOCK: assert property (pwrite_i && psel_i && penable_i && busy && !fire_now &&
        paddr_i == rps_pkg::ADDR_RAIL_EN |=> $stable(s_r.rail_en))
        else $error("rail enable written while sequencing");
    AST_HOST_WRITE: assert property (rail_wr |=> s_r.rail_en == $past(rail_wdata))
        else $error("rail enable write not reflected");
    AST_PD_END: assert property (s_r.st == rps_pkg::ST_PWR_DN &&
        s_r.pd_ms == PW'(rps_pkg::PD_TOTAL_MS) |=> s_r.st == $past(s_r.dest) && !s_r.dn)
        else $error("power-down did not end at its deadline");
    AST_ACTIVE_DN: assert property (s_r.st == rps_pkg::ST_ACTIVE && ok &&
        !power_enable_input_i |=> s_r.st == rps_pkg::ST_PWR_DN && s_r.dn)
        else $error("enable low did not start power-down");
    AST_OFF_WAKE: assert property (s_r.st == rps_pkg::ST_OFF && ok && pb_fall |=>
        s_r.st == rps_pkg::ST_WAIT_EN && s_r.up && s_r.strobe == 4'h1)
        else $error("button press did not wake from off");
    AST_NO_WAKE_FAULT: assert property ((s_r.st == rps_pkg::ST_OFF ||
        s_r.st == rps_pkg::ST_PRE_OFF) && !ok |=> $stable(s_r.st))
        else $error("woke while a fault was present");
    AST_SUSP_LEVEL: assert property (s_r.st == rps_pkg::ST_SUSPEND && ok &&
        power_enable_input_i |=> s_r.st == rps_pkg::ST_WAIT_EN)
        else $error("enable level did not wake from suspend");
    AST_WAIT_ACTIVE: assert property (s_r.st == rps_pkg::ST_WAIT_EN && ok &&
        power_enable_input_i |=> s_r.st == rps_pkg::ST_ACTIVE)
        else $error("enable did not move wait to active");
    AST_WAIT_TIMEOUT: assert property (s_r.st == rps_pkg::ST_WAIT_EN && ok &&
        !power_enable_input_i && pushbutton_input_i && adapter_detect_input_i &&
        s_r.wait_ms == WW'(WAIT_TIMEOUT_MS) |=> s_r.st == rps_pkg::ST_PWR_DN &&
        s_r.dest == rps_pkg::ST_OFF) else $error("wait timeout did not power down");

    COV_FULL_UP: cover property ($fell(s_r.up) && !s_r.dn);
    COV_ACTIVE: cover property (s_r.st == rps_pkg::ST_ACTIVE);
    COV_DN_DONE: cover property ($past(s_r.st) == rps_pkg::ST_PWR_DN &&
        s_r.st == rps_pkg::ST_SUSPEND);
endmodule : rps_sequencer
`default_nettype wire

// ### src/rps_pkg.sv
// shared constants and types of the rail power-up sequencer
// assumes a single 100 MHz clock and an APB register slave with 32-bit data
`default_nettype none
package rps_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1_000_000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    // sequence shape and timing
    localparam int N_RAILS_DEF = 8;
    localparam int N_STROBES = 10;
    localparam int N_DELAYS = 9;
    localparam int DLY_MIN_MS = 2;
    localparam int DLY_MAX_MS = 5;
    localparam int DLY_CODE_W = 2;
    localparam int DOWN_FACTOR = 10;
    localparam int WAIT_TIMEOUT_MS = 20_000;
    localparam int PD_TOTAL_MS = 500;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RAIL_EN = 8'h08;
    localparam logic [7:0] ADDR_STROBE = 8'h0c;
    localparam logic [7:0] ADDR_DELAY = 8'h10;
    // field positions
    localparam int CTRL_SUSPEND_SEL_BIT = 0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_UP_BIT = 4;
    localparam int STATUS_DN_BIT = 5;
    localparam int STROBE_FIELD_W = 4;
    // reset values: rail i on strobe i+3, every delay at its minimum
    localparam logic [31:0] STROBE_RST = 32'ha987_6543;
    localparam logic [17:0] DELAY_RST = 18'h0_0000;
    localparam logic CTRL_SUSPEND_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_PRE_OFF,
        ST_WAIT_EN,
        ST_ACTIVE,
        ST_SUSPEND,
        ST_PWR_DN
    } rps_state_t;
endpackage : rps_pkg
`default_nettype wire

// ### src/rps_apb_regs.sv
// apb register slave of the rail sequencer: configuration and readback
// assumes an apb master; answers with zero wait states
`default_nettype none
module rps_apb_regs #(
    parameter int N_RAILS = rps_pkg::N_RAILS_DEF
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic [N_RAILS-1:0] rail_en_i,
    input wire logic [31:0] status_i,
    input wire logic busy_i,
    output logic [4*N_RAILS-1:0] strobe_cfg_o,
    output logic [17:0] delay_cfg_o,
    output logic suspend_sel_o,
    output logic rail_wr_o,
    output logic [N_RAILS-1:0] rail_wdata_o
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [4*N_RAILS-1:0] strobe;
        logic [17:0] delay;
        logic susp;
    } rps_regs_t;

    rps_regs_t s_r;
    rps_regs_t s_nxt;
    logic setup;
    logic access;
    logic mapped;

    assign setup = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign mapped = (paddr_i == rps_pkg::ADDR_CTRL) || (paddr_i == rps_pkg::ADDR_STATUS) ||
                    (paddr_i == rps_pkg::ADDR_RAIL_EN) || (paddr_i == rps_pkg::ADDR_STROBE) ||
                    (paddr_i == rps_pkg::ADDR_DELAY);
    assign pready_o = 1'b1;
    // rail enables are locked while a sequence runs: error, write dropped
    assign pslverr_o = access & (~mapped |
                       (pwrite_i & busy_i & (paddr_i == rps_pkg::ADDR_RAIL_EN)));
    assign rail_wr_o = access & pwrite_i & ~busy_i & (paddr_i == rps_pkg::ADDR_RAIL_EN);
    assign rail_wdata_o = pwdata_i[N_RAILS-1:0];
    assign prdata_o = s_r.rdata;
    assign strobe_cfg_o = s_r.strobe;
    assign delay_cfg_o = s_r.delay;
    assign suspend_sel_o = s_r.susp;

    always_comb begin
        s_nxt = s_r;
        // read data latched in the setup cycle so it leaves a flop
        if (setup && !pwrite_i) begin
            s_nxt.rdata = 32'h0000_0000;
            unique case (paddr_i)
                rps_pkg::ADDR_CTRL: s_nxt.rdata[rps_pkg::CTRL_SUSPEND_SEL_BIT] = s_r.susp;
                rps_pkg::ADDR_STATUS: s_nxt.rdata = status_i;
                rps_pkg::ADDR_RAIL_EN: s_nxt.rdata[N_RAILS-1:0] = rail_en_i;
                rps_pkg::ADDR_STROBE: s_nxt.rdata[4*N_RAILS-1:0] = s_r.strobe;
                rps_pkg::ADDR_DELAY: s_nxt.rdata[17:0] = s_r.delay;
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (access && pwrite_i) begin
            unique case (paddr_i)
                rps_pkg::ADDR_CTRL: s_nxt.susp = pwdata_i[rps_pkg::CTRL_SUSPEND_SEL_BIT];
                rps_pkg::ADDR_STROBE: s_nxt.strobe = pwdata_i[4*N_RAILS-1:0];
                rps_pkg::ADDR_DELAY: s_nxt.delay = pwdata_i[17:0];
                default: s_nxt.susp = s_r.susp;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_r.rdata <= 32'h0000_0000;
            s_r.strobe <= rps_pkg::STROBE_RST[4*N_RAILS-1:0];
            s_r.delay <= rps_pkg::DELAY_RST;
            s_r.susp <= rps_pkg::CTRL_SUSPEND_RST;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : rps_apb_regs
`default_nettype wire

// ### test/rps_wake_host.sv
// wake pin driver standing in for the host side of the rail sequencer
// assumes the sequencer samples its wake pins on rising edges of clk_i
`default_nettype none
module rps_wake_host (
    input wire logic clk_i,
    output logic pb_o,
    output logic adapter_o,
    output logic enable_o,
    output logic supply_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // button and adapter pins rest high like pulled-up switches, enable rests low; supply arrival is not modelled
    initial begin
        pb_o = 1'b1;
        adapter_o = 1'b1;
        enable_o = 1'b0;
        supply_o = 1'b0;
    end
    // levels change just after an edge so the sequencer never sees a race
    task automatic set_pins(input logic pb, input logic ad, input logic en);
        @(posedge clk_i);
        pb_o <= pb;
        adapter_o <= ad;
        enable_o <= en;
    endtask : set_pins
endmodule : rps_wake_host
`default_nettype wire

// ### test/tb_rail_power_up_sequencer.sv
// self-checking bench of the rail sequencer: apb master, wake pins, fault flags
// assumes the short tick parameters below; expectations come from the register fields
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_rail_power_up_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPM = 10;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er, busy;
    logic undervoltage_lockout = 1'b0;
    logic overtemp_shutdown = 1'b0;
    logic pb, ad, en, sup;
    logic [7:0] rail_en, rail_dis;
    logic [7:0] prev = 8'h00;
    rps_pkg::rps_state_t state;
    int checks = 0;
    int mismatches = 0;
    int cyc = 0;
    int n;
    int rise_t[8];
    int fall_t[8];
    logic [17:0] dly;

    rps_wake_host host (.clk_i(clk_i), .pb_o(pb), .adapter_o(ad), .enable_o(en), .supply_o(sup));
    rps_sequencer #(.N_RAILS(8), .CYC_PER_MS(CPM), .WAIT_TIMEOUT_MS(20)) DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .pushbutton_input_i(pb),
        .adapter_detect_input_i(ad), .power_enable_input_i(en), .supply_arrival_i(sup),
        .undervoltage_lockout_i(undervoltage_lockout), .overtemp_shutdown_i(overtemp_shutdown), .rail_en_o(rail_en),
        .rail_discharge_o(rail_dis), .state_o(state), .seq_busy_o(busy));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // edge times of every rail, for order and spacing checks
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        prev <= rail_en;
        for (int i = 0; i < 8; i++) begin
            if (rail_en[i] === 1'b1 && prev[i] === 1'b0) rise_t[i] <= cyc;
            if (rail_en[i] === 1'b0 && prev[i] === 1'b1) fall_t[i] <= cyc;
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clk_i);
            k++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_st(input rps_pkg::rps_state_t s, input int lim);
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_st

    task automatic wait_rail(input int i);
        n = 0;
        while (rail_en[i] !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_rail

    // free-running ms tick may shorten the first ms of a delay by up to a whole ms
    function automatic logic in_win(input int got, input int nom, input int tol);
        return (got <= nom + 1) && (got >= nom - tol - 1);
    endfunction : in_win

    function automatic int dcode(input int k);
        return 2 + int'(dly[2*k-2 +: 2]);
    endfunction : dcode

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h18165f01));
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(1'b0, rps_pkg::ADDR_STROBE, 32'h0);
        `CHK("strobe reset", rps_pkg::STROBE_RST, rd);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped error", 1'b1, er);
        $display("test reset done");
        // rail 0 left out of the schedule and switched on by hand
        dly = 18'($urandom());
        apb(1'b1, rps_pkg::ADDR_DELAY, {14'h0, dly});
        apb(1'b1, rps_pkg::ADDR_STROBE, 32'ha987_6540);
        apb(1'b1, rps_pkg::ADDR_RAIL_EN, 32'h1);
        @(posedge clk_i);
        undervoltage_lockout <= 1'b1;
        host.set_pins(1'b0, 1'b1, 1'b0);
        repeat (5) @(posedge clk_i);
        `CHK("lockout blocks wake", rps_pkg::ST_OFF, state);
        host.set_pins(1'b1, 1'b1, 1'b0);
        undervoltage_lockout <= 1'b0;
        host.set_pins(1'b0, 1'b1, 1'b0);
        wait_st(rps_pkg::ST_WAIT_EN, 5);
        `CHK("button wake", rps_pkg::ST_WAIT_EN, state);
        wait_rail(3);
        `CHK("busy while sequencing", 1'b1, busy);
        apb(1'b1, rps_pkg::ADDR_RAIL_EN, 32'h0);
        `CHK("rail write while busy", 1'b1, er);
        wait_rail(7);
        repeat (3) @(posedge clk_i);
        `CHK("held in wait", rps_pkg::ST_WAIT_EN, state);
        `CHK("all rails up", 8'hff, rail_en);
        `CHK("sequence idle", 1'b0, busy);
        for (int i = 1; i < 7; i++) begin
            `CHK("up gap", 1'b1, in_win(rise_t[i+1] - rise_t[i], dcode(i + 3) * CPM, CPM));
        end
        apb(1'b0, rps_pkg::ADDR_RAIL_EN, 32'h0);
        `CHK("enable bits", 8'hff, rd[7:0]);
        host.set_pins(1'b0, 1'b1, 1'b1);
        wait_st(rps_pkg::ST_ACTIVE, 5);
        `CHK("enable to active", rps_pkg::ST_ACTIVE, state);
        host.set_pins(1'b1, 1'b0, 1'b1);
        repeat (20) @(posedge clk_i);
        `CHK("detect ignored", rps_pkg::ST_ACTIVE, state);
        host.set_pins(1'b1, 1'b1, 1'b0);
        wait_st(rps_pkg::ST_PWR_DN, 5);
        `CHK("enable low powers down", rps_pkg::ST_PWR_DN, state);
        wait_st(rps_pkg::ST_OFF, 6000);
        `CHK("down total", 1'b1, in_win(n, 500 * CPM, 40));
        for (int i = 1; i < 7; i++) begin
            `CHK("down gap", 1'b1, in_win(fall_t[i] - fall_t[i+1], dcode(i + 3) * CPM * 10, CPM));
        end
        `CHK("unsequenced rail kept", 8'h01, rail_en);
        `CHK("discharge on", 1'b1, rail_dis[7]);
        $display("test sequence done");
        host.set_pins(1'b1, 1'b0, 1'b0);
        host.set_pins(1'b1, 1'b1, 1'b0);
        // state moves at the edge just taken; it is seen one edge later
        wait_st(rps_pkg::ST_WAIT_EN, 5);
        `CHK("detect wake", rps_pkg::ST_WAIT_EN, state);
        wait_st(rps_pkg::ST_PWR_DN, 400);
        `CHK("wait timeout", 1'b1, (n > 180) && (n <= 205));
        wait_st(rps_pkg::ST_OFF, 6000);
        `CHK("back to off", rps_pkg::ST_OFF, state);
        $display("test timeout done");
        apb(1'b1, rps_pkg::ADDR_CTRL, 32'h1);
        host.set_pins(1'b1, 1'b1, 1'b1);
        wait_st(rps_pkg::ST_ACTIVE, 10);
        `CHK("enable wake", rps_pkg::ST_ACTIVE, state);
        host.set_pins(1'b1, 1'b1, 1'b0);
        wait_st(rps_pkg::ST_SUSPEND, 6000);
        `CHK("suspend", rps_pkg::ST_SUSPEND, state);
        host.set_pins(1'b1, 1'b1, 1'b1);
        wait_st(rps_pkg::ST_ACTIVE, 10);
        `CHK("suspend level wake", rps_pkg::ST_ACTIVE, state);
        @(posedge clk_i);
        overtemp_shutdown <= 1'b1;
        wait_st(rps_pkg::ST_PRE_OFF, 6000);
        `CHK("fault to pre-off", rps_pkg::ST_PRE_OFF, state);
        host.set_pins(1'b1, 1'b1, 1'b0);
        overtemp_shutdown <= 1'b0;
        host.set_pins(1'b0, 1'b1, 1'b0);
        wait_st(rps_pkg::ST_WAIT_EN, 5);
        `CHK("pre-off wake", rps_pkg::ST_WAIT_EN, state);
        $display("test wake sources done");
        print_verdict();
    end
endmodule : tb_rail_power_up_sequencer
`default_nettype wire
